// ==== igc_map.vh ====
// Address map, storage layout and encodings for the group and clear-pending registers.
`ifndef IGC_MAP_VH
`define IGC_MAP_VH

// Register bank base offsets; each bank is a run of aligned 32-bit words.
`define IGC_GRP_BASE     16'h0080
`define IGC_EGRP_BASE    16'h1000
`define IGC_ECLR_BASE    16'h1800
`define IGC_MOD_BASE     16'h0d00
`define IGC_REGION_MASK  16'hfff0

// Storage sizes: four words per range, banked word zero for eight elements.
`define IGC_NORM_REGS    6'h04
`define IGC_EXT_REGS     6'h04
`define IGC_PE_BANKS     4'h8
`define IGC_MEM_WORDS    18
`define IGC_MEM_AW       5
`define IGC_NORM_IDS     96
`define IGC_EXT_IDS      128
`define IGC_CODE_IDS     224

// Storage word indices; a bank index is added to the base.
`define IGC_W_NORM       5'h07
`define IGC_W_EXT        5'h0b
`define IGC_W_MOD        5'h0e
`define IGC_W_NORM_LO    8
`define IGC_W_EXT_LO     11
`define IGC_W_MOD_LO     15

// Reset value and all-ones mask word.
`define IGC_RESET_WORD   32'h00000000
`define IGC_ONES_WORD    32'hffffffff

// Two-bit group selection codes, modifier bit first.
`define IGC_G0S          2'h0
`define IGC_NONSECURE_GROUP_ONE         2'h1
`define IGC_G1S          2'h2

`endif

// ==== igc_word_bank.v ====
// Word store for group status and modifier bits with masked writes and registered reads.
`timescale 1ns/10ps
`include "igc_map.vh"

module igc_word_bank (
  clk,
  reset,
  wr_en,
  wr_addr,
  wr_mask,
  wr_data,
  rd_addr,
  rd_data,
  words_flat
);
  input  wire                                clk;
  input  wire                                reset;
  input  wire                                wr_en;
  input  wire [`IGC_MEM_AW-1:0]              wr_addr;
  input  wire [31:0]                         wr_mask;
  input  wire [31:0]                         wr_data;
  input  wire [`IGC_MEM_AW-1:0]              rd_addr;
  output reg  [31:0]                         rd_data;
  output reg  [`IGC_MEM_WORDS*32-1:0]        words_flat;

  genvar i;

  // Each word updates only the bits selected by the mask, so hidden bits keep their value.
  generate
    for (i = 0; i < `IGC_MEM_WORDS; i = i + 1) begin : g_word
      always @(posedge clk or posedge reset) begin
        if (reset) begin
          words_flat[i*32 +: 32] <= `IGC_RESET_WORD;
        end else if (wr_en && (wr_addr == i)) begin
          words_flat[i*32 +: 32] <= (words_flat[i*32 +: 32] & ~wr_mask) | (wr_data & wr_mask);
        end
      end
    end
  endgenerate

  // Read data is sampled every cycle from the addressed word.
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      rd_data <= `IGC_RESET_WORD;
    end else if (rd_addr < `IGC_MEM_WORDS) begin
      rd_data <= words_flat[rd_addr*32 +: 32];
    end else begin
      rd_data <= `IGC_RESET_WORD;
    end
  end

endmodule

// ==== igc_group_pend.v ====
// Group status, group modifier and extended clear-pending register logic.
`timescale 1ns/10ps
`include "igc_map.vh"

module igc_group_pend (
  clk,
  reset,
  acc_valid,
  acc_write,
  acc_addr,
  acc_wdata,
  acc_secure,
  acc_pe_num,
  acc_busy,
  acc_ready,
  acc_rdata,
  security_disable,
  are_secure,
  are_nonsecure,
  extended_shared_present,
  extended_shared_range,
  interrupt_lines_field,
  ext_pending,
  ext_sw_pending,
  ext_level,
  ext_line,
  ext_pending_clear,
  group_code,
  pe_group_bank
);
  input  wire                        clk;
  input  wire                        reset;
  input  wire                        acc_valid;
  input  wire                        acc_write;
  input  wire [15:0]                 acc_addr;
  input  wire [31:0]                 acc_wdata;
  input  wire                        acc_secure;
  input  wire [3:0]                  acc_pe_num;
  output wire                        acc_busy;
  output wire                        acc_ready;
  output wire [31:0]                 acc_rdata;
  input  wire                        security_disable;
  input  wire                        are_secure;
  input  wire                        are_nonsecure;
  input  wire                        extended_shared_present;
  input  wire [4:0]                  extended_shared_range;
  input  wire [4:0]                  interrupt_lines_field;
  input  wire [`IGC_EXT_IDS-1:0]     ext_pending;
  input  wire [`IGC_EXT_IDS-1:0]     ext_sw_pending;
  input  wire [`IGC_EXT_IDS-1:0]     ext_level;
  input  wire [`IGC_EXT_IDS-1:0]     ext_line;
  output wire [`IGC_EXT_IDS-1:0]     ext_pending_clear;
  output wire [`IGC_CODE_IDS*2-1:0]  group_code;
  output wire [`IGC_PE_BANKS*32-1:0] pe_group_bank;

  // One-hot access states.
  localparam [2:0] ST_IDLE = 3'h1;
  localparam [2:0] ST_READ = 3'h2;
  localparam [2:0] ST_DONE = 3'h4;
  localparam       IX_IDLE = 0;
  localparam       IX_DONE = 2;

  reg  [2:0]                  state_reg;
  reg  [2:0]                  state_next;
  reg  [31:0]                 rdata_reg;
  reg  [31:0]                 rmask_reg;
  reg  [31:0]                 rpend_reg;
  reg                         rsel_pend_reg;
  reg                         rwrite_reg;
  reg  [`IGC_EXT_IDS-1:0]     clear_reg;
  reg  [`IGC_EXT_IDS-1:0]     clear_next;
  reg  [`IGC_MEM_AW-1:0]      mem_idx;
  reg  [31:0]                 mask;
  reg                         sel_pend;
  reg                         sel_mem;

  wire [`IGC_MEM_WORDS*32-1:0] words_flat;
  wire [31:0]                  mem_rdata;
  wire [1:0]                   idx;
  wire [5:0]                   lines_cnt;
  wire [5:0]                   range_cnt;
  wire [5:0]                   norm_impl;
  wire [5:0]                   ext_impl;
  wire                         nsec_block;
  wire                         pe_ok;
  wire                         ext_ok;
  wire                         take;
  wire [31:0]                  cur_word;
  wire [31:0]                  are_vec;
  wire [31:0]                  sec_blk;
  wire [31:0]                  pend_word;
  wire [31:0]                  lvl_word;
  wire [31:0]                  line_word;
  wire [31:0]                  sw_word;
  wire [31:0]                  clr_word;
  wire [`IGC_CODE_IDS-1:0]     grp_all;
  wire [`IGC_CODE_IDS-1:0]     mod_all;
  reg  [`IGC_CODE_IDS*2-1:0]   code_reg;

  // A request is taken only while idle; the requester sees busy otherwise.
  assign take     = acc_valid & state_reg[IX_IDLE];
  assign acc_busy = ~state_reg[IX_IDLE];
  assign acc_ready = state_reg[IX_DONE];
  assign acc_rdata = rdata_reg;
  assign idx      = acc_addr[3:2];

  // Implemented register counts, capped at the storage that exists.
  assign lines_cnt = {1'b0, interrupt_lines_field} + 6'h01;
  assign range_cnt = {1'b0, extended_shared_range} + 6'h01;
  assign norm_impl = (lines_cnt > `IGC_NORM_REGS) ? `IGC_NORM_REGS : lines_cnt;
  assign ext_impl  = (range_cnt > `IGC_EXT_REGS) ? `IGC_EXT_REGS : range_cnt;

  // Secure-only state is hidden from non-secure accesses unless security is disabled.
  assign nsec_block = ~security_disable & ~acc_secure;
  assign pe_ok      = ({1'b0, acc_pe_num} < {1'b0, `IGC_PE_BANKS});
  assign ext_ok     = extended_shared_present & ({4'h0, idx} < ext_impl);

  // Word index in storage for the addressed register.
  always @* begin
    mem_idx  = `IGC_W_NORM;
    sel_pend = 1'b0;
    sel_mem  = 1'b0;
    if ((acc_addr & `IGC_REGION_MASK) == `IGC_GRP_BASE) begin
      sel_mem = 1'b1;
      if (idx == 2'h0) begin
        mem_idx = {2'h0, acc_pe_num[2:0]};
      end else begin
        mem_idx = `IGC_W_NORM + {3'h0, idx};
      end
    end else if ((acc_addr & `IGC_REGION_MASK) == `IGC_EGRP_BASE) begin
      sel_mem = 1'b1;
      mem_idx = `IGC_W_EXT + {3'h0, idx};
    end else if ((acc_addr & `IGC_REGION_MASK) == `IGC_ECLR_BASE) begin
      sel_pend = 1'b1;
      mem_idx  = `IGC_W_EXT + {3'h0, idx};
    end else if ((acc_addr & `IGC_REGION_MASK) == `IGC_MOD_BASE) begin
      sel_mem = 1'b1;
      mem_idx = `IGC_W_MOD + {3'h0, idx};
    end
  end

  // Group bits of the addressed word decide each bit's security state.
  assign cur_word = words_flat[mem_idx*32 +: 32];

  // Affinity routing per bit, chosen by the security state that its group bit gives.
  assign are_vec = security_disable ? {32{are_secure}} :
                   ((cur_word & {32{are_nonsecure}}) | (~cur_word & {32{are_secure}}));

  // Secure interrupts are those in group zero.
  assign sec_blk = nsec_block ? ~cur_word : `IGC_RESET_WORD;

  // Visible-bit mask for the access; zero bits read as zero and ignore writes.
  always @* begin
    mask = `IGC_RESET_WORD;
    if ((acc_addr & `IGC_REGION_MASK) == `IGC_GRP_BASE) begin
      if (({4'h0, idx} < norm_impl) && !nsec_block) begin
        if (idx != 2'h0) begin
          mask = `IGC_ONES_WORD;
        end else if (pe_ok) begin
          mask = ~are_vec;
        end
      end
    end else if ((acc_addr & `IGC_REGION_MASK) == `IGC_EGRP_BASE) begin
      if (ext_ok) begin
        mask = are_vec & ~sec_blk;
      end
    end else if ((acc_addr & `IGC_REGION_MASK) == `IGC_ECLR_BASE) begin
      if (ext_ok) begin
        mask = are_vec & ~sec_blk;
      end
    end else if ((acc_addr & `IGC_REGION_MASK) == `IGC_MOD_BASE) begin
      if ((idx != 2'h0) && ({4'h0, idx} < norm_impl) && are_secure &&
          !security_disable && acc_secure) begin
        mask = `IGC_ONES_WORD;
      end
    end
  end

  // Pending state of the addressed extended word.
  assign pend_word = ext_pending[idx*32 +: 32];
  assign lvl_word  = ext_level[idx*32 +: 32];
  assign line_word = ext_line[idx*32 +: 32];
  assign sw_word   = ext_sw_pending[idx*32 +: 32];

  // Input-held level interrupts are not cleared, every other written one that is pending and visible is.
  assign clr_word = acc_wdata & mask & pend_word &
                    ~(lvl_word & line_word & ~sw_word);

  // Clear pulses go only to the word that the write addressed.
  genvar w;
  generate
    for (w = 0; w < `IGC_EXT_REGS; w = w + 1) begin : g_clr
      always @* begin
        clear_next[w*32 +: 32] = `IGC_RESET_WORD;
        if (take && acc_write && sel_pend && (idx == w)) begin
          clear_next[w*32 +: 32] = clr_word;
        end
      end
    end
  endgenerate

  // Storage of group status and modifier words.
  igc_word_bank u_bank (
    .clk        (clk),
    .reset      (reset),
    .wr_en      (take & acc_write & sel_mem),
    .wr_addr    (mem_idx),
    .wr_mask    (mask),
    .wr_data    (acc_wdata),
    .rd_addr    (mem_idx),
    .rd_data    (mem_rdata),
    .words_flat (words_flat)
  );

  // Access sequencer: take, read, answer, back to idle.
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (acc_valid) begin
          state_next = ST_READ;
        end
      end
      ST_READ: begin
        state_next = ST_DONE;
      end
      ST_DONE: begin
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // Sequencer state and the details of the taken request.
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      state_reg     <= ST_IDLE;
      rmask_reg     <= `IGC_RESET_WORD;
      rpend_reg     <= `IGC_RESET_WORD;
      rsel_pend_reg <= 1'b0;
      rwrite_reg    <= 1'b0;
      clear_reg     <= {`IGC_EXT_IDS{1'b0}};
    end else begin
      state_reg <= state_next;
      clear_reg <= clear_next;
      if (take) begin
        rmask_reg     <= mask;
        rpend_reg     <= pend_word & mask;
        rsel_pend_reg <= sel_pend;
        rwrite_reg    <= acc_write;
      end
    end
  end

  // Read data is formed once the stored word is out of the bank.
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata_reg <= `IGC_RESET_WORD;
    end else if (state_reg == ST_READ) begin
      if (rwrite_reg) begin
        rdata_reg <= `IGC_RESET_WORD;
      end else if (rsel_pend_reg) begin
        rdata_reg <= rpend_reg;
      end else begin
        rdata_reg <= mem_rdata & rmask_reg;
      end
    end
  end

  assign ext_pending_clear = clear_reg;

  // Shared interrupts in order: normal words 1 to 3, then extended words.
  assign grp_all = {words_flat[`IGC_W_EXT*32 +: `IGC_EXT_IDS],
                    words_flat[`IGC_W_NORM_LO*32 +: `IGC_NORM_IDS]};
  assign mod_all = {{`IGC_EXT_IDS{1'b0}},
                    words_flat[`IGC_W_MOD_LO*32 +: `IGC_NORM_IDS]};

  // Group code per interrupt, registered so a change lands in one step.
  genvar b;
  generate
    for (b = 0; b < `IGC_CODE_IDS; b = b + 1) begin : g_code
      wire are_b;
      assign are_b = security_disable ? are_secure :
                     (grp_all[b] ? are_nonsecure : are_secure);
      always @(posedge clk or posedge reset) begin
        if (reset) begin
          code_reg[b*2 +: 2] <= `IGC_G0S;
        end else if (mod_all[b] && are_b && !grp_all[b]) begin
          code_reg[b*2 +: 2] <= `IGC_G1S;
        end else if (grp_all[b]) begin
          code_reg[b*2 +: 2] <= `IGC_NONSECURE_GROUP_ONE;
        end else begin
          code_reg[b*2 +: 2] <= `IGC_G0S;
        end
      end
    end
  endgenerate

  assign group_code = code_reg;

  // Banked group word zero of each element is the redistributor copy.
  assign pe_group_bank = words_flat[`IGC_PE_BANKS*32-1:0];

endmodule

// ==== igc_group_pend_checker.sv ====
// Concurrent checks on the ports of the group and clear-pending register block.
`timescale 1ns/10ps
`include "igc_map.vh"

module igc_group_pend_checker (
  input wire logic                        clk,
  input wire logic                        reset,
  input wire logic                        acc_valid,
  input wire logic                        acc_write,
  input wire logic [15:0]                 acc_addr,
  input wire logic                        acc_secure,
  input wire logic                        acc_busy,
  input wire logic                        acc_ready,
  input wire logic [31:0]                 acc_rdata,
  input wire logic                        security_disable,
  input wire logic [`IGC_EXT_IDS-1:0]     ext_pending,
  input wire logic [`IGC_EXT_IDS-1:0]     ext_sw_pending,
  input wire logic [`IGC_EXT_IDS-1:0]     ext_level,
  input wire logic [`IGC_EXT_IDS-1:0]     ext_line,
  input wire logic [`IGC_EXT_IDS-1:0]     ext_pending_clear,
  input wire logic [`IGC_CODE_IDS*2-1:0]  group_code
);
  logic [`IGC_CODE_IDS-1:0] code_hi;
  logic [`IGC_CODE_IDS-1:0] code_lo;

  // Splits every group code into its modifier half and its status half.
  always_comb begin
    for (int i = 0; i < `IGC_CODE_IDS; i++) begin
      code_hi[i] = group_code[2*i+1];
      code_lo[i] = group_code[2*i];
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  chk_answer_timing: assert property (
    (acc_valid && !acc_busy) |=> (acc_busy && !acc_ready) ##1 (acc_busy && acc_ready) ##1 !acc_busy)
    else $error("Access answer timing is wrong.");
  chk_ready_single: assert property (acc_ready |=> !acc_ready)
    else $error("Ready stands longer than one cycle.");
  chk_clear_single: assert property ((|ext_pending_clear) |=> ext_pending_clear == 0)
    else $error("Clear pulse stands longer than one cycle.");
  chk_clear_cause: assert property (
    (|ext_pending_clear) |-> $past(acc_valid && !acc_busy && acc_write && acc_addr[15:4] == 12'h180))
    else $error("Clear pulse without a clear write.");
  chk_clear_pending: assert property ((ext_pending_clear & ~$past(ext_pending)) == 0)
    else $error("Clear pulse for an interrupt that was not pending.");
  chk_clear_held: assert property (
    (ext_pending_clear & $past(ext_level & ext_line & ~ext_sw_pending)) == 0)
    else $error("Clear pulse for a level interrupt held by its input.");
  chk_write_rdata: assert property ((acc_ready && $past(acc_write, 2)) |-> acc_rdata == 0)
    else $error("Write answer carries data.");
  chk_ns_group_zero: assert property (
    (acc_ready && $past(!security_disable && !acc_secure && acc_addr[15:4] == 12'h008, 2))
    |-> acc_rdata == 0)
    else $error("Non-secure group read is not zero.");
  chk_unmapped_zero: assert property (
    (acc_ready && $past(acc_addr[15:12] == 4'h2, 2)) |-> acc_rdata == 0)
    else $error("Unmapped read is not zero.");
  chk_code_reserved: assert property ((code_hi & code_lo) == 0)
    else $error("Group code shows the reserved value.");

  // Main scenarios.
  cover property (acc_valid && !acc_busy && acc_write);
  cover property (|ext_pending_clear);
  cover property (acc_ready && acc_rdata != 0);
endmodule

// ==== igc_group_pend_bench.sv ====
// Self-checking bench for the group and clear-pending register block.
`timescale 1ns/10ps
`include "igc_map.vh"

`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("Error at %0t: got %h expected %h", $time, got, exp); end end

module igc_group_pend_bench;
  typedef struct packed {
    logic        w;
    logic [15:0] a;
    logic [31:0] d;
    logic        s;
    logic [31:0] e;
  } igc_row_t;

  logic clk, reset, acc_valid, acc_write, acc_secure, acc_busy, acc_ready;
  logic security_disable, are_secure, are_nonsecure, extended_shared_present;
  logic [15:0]  acc_addr;
  logic [31:0]  acc_wdata, acc_rdata, rd, gv, mv;
  logic [3:0]   acc_pe_num;
  logic [4:0]   extended_shared_range, interrupt_lines_field;
  logic [127:0] ext_pending, ext_sw_pending, ext_level, ext_line, ext_pending_clear, clr;
  logic [447:0] group_code;
  logic [255:0] pe_group_bank;
  igc_row_t     rows [0:23];
  int           n_mismatch = 0;
  int           checks = 0;

  igc_group_pend dut (.clk(clk), .reset(reset), .acc_valid(acc_valid), .acc_write(acc_write),
    .acc_addr(acc_addr), .acc_wdata(acc_wdata), .acc_secure(acc_secure),
    .acc_pe_num(acc_pe_num), .acc_busy(acc_busy), .acc_ready(acc_ready),
    .acc_rdata(acc_rdata), .security_disable(security_disable), .are_secure(are_secure),
    .are_nonsecure(are_nonsecure), .extended_shared_present(extended_shared_present),
    .extended_shared_range(extended_shared_range),
    .interrupt_lines_field(interrupt_lines_field), .ext_pending(ext_pending),
    .ext_sw_pending(ext_sw_pending), .ext_level(ext_level), .ext_line(ext_line),
    .ext_pending_clear(ext_pending_clear), .group_code(group_code),
    .pe_group_bank(pe_group_bank));

  // Prints the verdict and ends the run.
  task automatic close_out;
    if (n_mismatch == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // One register access: waits for idle, offers it for one edge, collects answer and pulse.
  task automatic acc(input logic w, input logic [15:0] a, input logic [31:0] d,
                     input logic s);
    int k;
    k = 0;
    while (acc_busy !== 1'h0 && k < 10) begin
      @(negedge clk);
      k++;
    end
    acc_valid = 1'h1;
    acc_write = w;
    acc_addr = a;
    acc_wdata = d;
    acc_secure = s;
    @(negedge clk);
    acc_valid = 1'h0;
    clr = ext_pending_clear;
    k = 0;
    while (acc_ready !== 1'h1 && k < 10) begin
      @(negedge clk);
      k++;
    end
    if (k == 10) n_mismatch++;
    rd = acc_rdata;
  endtask

  // Free-running clock.
  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end

  // Watchdog against a hung handshake.
  initial begin
    #20000;
    n_mismatch++;
    close_out;
  end

  // Main sequence.
  initial begin
    {acc_valid, acc_write, acc_secure, security_disable} = 4'h0;
    {are_secure, are_nonsecure, extended_shared_present} = 3'h7;
    {acc_addr, acc_wdata, acc_pe_num} = 52'h0;
    extended_shared_range = 5'h01;
    interrupt_lines_field = 5'h02;
    {ext_pending, ext_sw_pending, ext_level, ext_line} = 512'h0;
    rows[0]  = '{1'h0, 16'h1004, 32'h0, 1'h1, 32'h0};
    rows[1]  = '{1'h0, 16'h1800, 32'h0, 1'h1, 32'h0};
    rows[2]  = '{1'h0, 16'h0084, 32'h0, 1'h1, 32'h0};
    rows[3]  = '{1'h1, 16'h0084, 32'ha5a5a5a5, 1'h1, 32'h0};
    rows[4]  = '{1'h0, 16'h0084, 32'h0, 1'h1, 32'ha5a5a5a5};
    rows[5]  = '{1'h0, 16'h0084, 32'h0, 1'h0, 32'h0};
    rows[6]  = '{1'h1, 16'h0084, 32'hffffffff, 1'h0, 32'h0};
    rows[7]  = '{1'h0, 16'h0084, 32'h0, 1'h1, 32'ha5a5a5a5};
    rows[8]  = '{1'h1, 16'h008c, 32'h12345678, 1'h1, 32'h0};
    rows[9]  = '{1'h0, 16'h008c, 32'h0, 1'h1, 32'h0};
    rows[10] = '{1'h1, 16'h0080, 32'hffffffff, 1'h1, 32'h0};
    rows[11] = '{1'h0, 16'h0080, 32'h0, 1'h1, 32'h0};
    rows[12] = '{1'h1, 16'h1000, 32'h0000ffff, 1'h1, 32'h0};
    rows[13] = '{1'h0, 16'h1000, 32'h0, 1'h0, 32'h0000ffff};
    rows[14] = '{1'h1, 16'h1000, 32'hffffffff, 1'h0, 32'h0};
    rows[15] = '{1'h0, 16'h1000, 32'h0, 1'h1, 32'h0000ffff};
    rows[16] = '{1'h1, 16'h1008, 32'hffffffff, 1'h1, 32'h0};
    rows[17] = '{1'h0, 16'h1008, 32'h0, 1'h1, 32'h0};
    rows[18] = '{1'h1, 16'h0d04, 32'h00ff00ff, 1'h1, 32'h0};
    rows[19] = '{1'h0, 16'h0d04, 32'h0, 1'h1, 32'h00ff00ff};
    rows[20] = '{1'h0, 16'h0d04, 32'h0, 1'h0, 32'h0};
    rows[21] = '{1'h0, 16'h2000, 32'h0, 1'h1, 32'h0};
    rows[22] = '{1'h1, 16'h1004, 32'h80000001, 1'h1, 32'h0};
    rows[23] = '{1'h0, 16'h1004, 32'h0, 1'h1, 32'h80000001};
    reset = 1'h1;
    repeat (20) @(negedge clk);
    reset = 1'h0;
    `CHK(group_code, 448'h0)
    `CHK(pe_group_bank, 256'h0)
    for (int i = 0; i < 24; i++) begin
      acc(rows[i].w, rows[i].a, rows[i].d, rows[i].s);
      `CHK(rd, rows[i].e)
    end
    // Group codes from status and modifier words, reserved code folded.
    gv = 32'ha5a5a5a5;
    mv = 32'h00ff00ff;
    for (int i = 0; i < 32; i++) begin
      `CHK(group_code[2*i+:2], (mv[i] && !gv[i]) ? 2'h2 : {1'h0, gv[i]})
    end
    `CHK(group_code[192+:2], 2'h1)
    `CHK(group_code[224+:2], 2'h0)
    // Clear-pending reads and writes, a held level line and a non-secure writer.
    ext_pending = {64'h0, 32'h00000008, 32'h00030f0c};
    ext_level = 128'h300;
    ext_line = 128'h300;
    ext_sw_pending = 128'h200;
    acc(1'h0, 16'h1800, 32'h0, 1'h1);
    `CHK(rd, 32'h00030f0c)
    acc(1'h0, 16'h1800, 32'h0, 1'h0);
    `CHK(rd, 32'h00000f0c)
    acc(1'h1, 16'h1800, 32'h000f0b0e, 1'h0);
    `CHK(clr, 128'h0a0c)
    acc(1'h1, 16'h1804, 32'h00000008, 1'h1);
    `CHK(clr, 128'h800000000)
    acc(1'h1, 16'h1800, 32'h0, 1'h1);
    `CHK(clr, 128'h0)
    // Routing off: banked word zero per element, modifier and extended bits zero.
    are_secure = 1'h0;
    are_nonsecure = 1'h0;
    acc(1'h0, 16'h0d04, 32'h0, 1'h1);
    `CHK(rd, 32'h0)
    acc(1'h0, 16'h1000, 32'h0, 1'h1);
    `CHK(rd, 32'h0)
    `CHK(group_code[2+:2], 2'h0)
    acc_pe_num = 4'h2;
    acc(1'h1, 16'h0080, 32'h000000f0, 1'h1);
    acc(1'h0, 16'h0080, 32'h0, 1'h1);
    `CHK(rd, 32'h000000f0)
    `CHK(pe_group_bank[64+:32], 32'h000000f0)
    acc_pe_num = 4'h3;
    acc(1'h0, 16'h0080, 32'h0, 1'h1);
    `CHK(rd, 32'h0)
    acc_pe_num = 4'h9;
    acc(1'h1, 16'h0080, 32'hffffffff, 1'h1);
    acc(1'h0, 16'h0080, 32'h0, 1'h1);
    `CHK(rd, 32'h0)
    // Second reset in mid-run.
    reset = 1'h1;
    repeat (2) @(negedge clk);
    reset = 1'h0;
    `CHK(group_code, 448'h0)
    close_out;
  end
endmodule

bind igc_group_pend igc_group_pend_checker chk (.clk(clk), .reset(reset),
  .acc_valid(acc_valid), .acc_write(acc_write), .acc_addr(acc_addr),
  .acc_secure(acc_secure), .acc_busy(acc_busy), .acc_ready(acc_ready),
  .acc_rdata(acc_rdata), .security_disable(security_disable),
  .ext_pending(ext_pending), .ext_sw_pending(ext_sw_pending), .ext_level(ext_level),
  .ext_line(ext_line), .ext_pending_clear(ext_pending_clear), .group_code(group_code));
